// ### bench/tb_lfo_watchdog_reset_timer.sv
module tb_lfo_watchdog_reset_timer
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'h0, reset = 1'h1, lfoClk = 1'h0, lfoRun = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp, rsp;
  logic [2:0]  lfoDiv = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid, sysResetReq, rstPinOe, irq;
  int          failures = 0, num_checks = 0, n;

  wdt_timer i_dut (.mclk, .reset, .lfoClk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .sysResetReq, .rstPinOe, .irq);

  ////////////////////////////////////////////////////////////////////////////////
  // clock and a fast oscillator stand-in, one tick per 8 mclk
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    lfoDiv <= lfoRun ? lfoDiv + 3'h1 : 3'h0;
    lfoClk <= lfoDiv[2];
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // bus write, both channels offered together, held until taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    do
    begin
      @(negedge mclk);
      ha = awvalid & awready; hw = wvalid & wready; hb = bvalid; rsp = bresp;
      @(posedge mclk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
    end while (hb !== 1'h1);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ha, hb;
    logic [31:0] d;
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do
    begin
      @(negedge mclk);
      ha = arvalid & arready; hb = rvalid; d = rdata; rsp = rresp;
      @(posedge mclk);
      if (ha) arvalid <= 1'h0;
    end while (hb !== 1'h1);
    chk("rdata", e, d);
    chk("rresp", 32'(er), 32'(rsp));
  endtask : rd
  task automatic sys_reset();
    reset <= 1'h1; lfoRun <= 1'h0;
    repeat (6) @(posedge mclk);
    reset <= 1'h0;
  endtask : sys_reset
  // cycles until the reset request pulse
  task automatic wait_req();
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end while (sysResetReq !== 1'h1 && n < 1200);
    chk("rstPinOe", 32'h0, 32'(rstPinOe));
    @(posedge mclk);
  endtask : wait_req

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    sys_reset();
    rd(CTRL_OFS, 32'h71, RESP_OKAY);
    rd(STAT_OFS, 32'h0, RESP_OKAY);
    rd(4'h2, 32'h0, RESP_SLVERR);
  endtask : t_defaults
  task automatic t_overflow();
    sys_reset();
    wr(ENABLE_OFS, 32'h1);
    wr(CTRL_OFS, 32'h1);
    lfoRun <= 1'h1;
    wait_req();
    chk("ovf cycles", 32'h1, 32'(n > 450 && n < 700));
    lfoRun <= 1'h0;
    repeat (20) @(posedge mclk);
    chk("irq set", 32'h1, 32'(irq));
    wr(ENABLE_OFS, 32'h0);
    chk("irq masked", 32'h0, 32'(irq));
    wr(ENABLE_OFS, 32'h1);
    wr(CLEAR_OFS, 32'h1);
    rd(STAT_OFS, 32'h0, RESP_OKAY);
    chk("irq clear", 32'h0, 32'(irq));
  endtask : t_overflow
  task automatic t_restart();
    sys_reset();
    wr(CTRL_OFS, 32'h1);
    lfoRun <= 1'h1;
    repeat (320) @(posedge mclk);
    wr(CTRL_OFS, 32'h101);
    wait_req();
    chk("restart cycles", 32'h1, 32'(n > 450 && n < 700));
  endtask : t_restart
  task automatic t_disable();
    sys_reset();
    wr(CTRL_OFS, 32'h0);
    lfoRun <= 1'h1;
    wait_req();
    chk("no request", 32'h1, 32'(n >= 1200));
  endtask : t_disable
  task automatic t_lock();
    sys_reset();
    wr(CTRL_OFS, 32'h3);
    wr(CTRL_OFS, 32'h70);
    chk("bresp", 32'(RESP_OKAY), 32'(rsp));
    rd(CTRL_OFS, 32'h3, RESP_OKAY);
    rd(STAT_OFS, 32'h2, RESP_OKAY);
    lfoRun <= 1'h1;
    wait_req();
    chk("locked ovf", 32'h1, 32'(n < 700));
    sys_reset();
    rd(CTRL_OFS, 32'h71, RESP_OKAY);
  endtask : t_lock

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  initial
  begin
    t_defaults();
    t_overflow();
    t_restart();
    t_disable();
    t_lock();
    results();
  end
  // hang guard, well beyond the expected run
  initial
  begin
    #200000;
    failures++;
    results();
  end
endmodule : tb_lfo_watchdog_reset_timer

// ### hdl/wdt_timer.sv
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
module wdt_timer
  import wdt_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        lfoClk,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             sysResetReq,
  output logic             rstPinOe,
  output logic             irq
);
  //////////////////////////////////////////////////////////////////
  // oscillator synchroniser and edge detect
  logic             lfoMeta;
  logic             lfoSync;
  logic             lfoLast;
  logic             lfoTick;
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      lfoMeta <= 1'b0;
      lfoSync <= 1'b0;
      lfoLast <= 1'b0;
    end
    else
    begin
      lfoMeta <= lfoClk;
      lfoSync <= lfoMeta;
      lfoLast <= lfoSync;
    end
  end
  assign lfoTick = lfoSync & ~lfoLast;

  //////////////////////////////////////////////////////////////////
  // bus write channel
  logic             awHeld;
  logic             wHeld;
  logic [3:0]       awAddr;
  logic [31:0]      wData;
  logic [3:0]       wStrb;
  logic             doWrite;
  assign awready = ~awHeld & ~bvalid;
  assign wready  = ~wHeld & ~bvalid;
  assign doWrite = awHeld & wHeld & ~bvalid;
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 4'h0;
      wData  <= 32'h0;
      wStrb  <= 4'h0;
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld <= 1'b1;
        awAddr <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld <= 1'b1;
        wData <= wdata;
        wStrb <= wstrb;
      end
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= (awAddr == CTRL_OFS || awAddr == CLEAR_OFS || awAddr == ENABLE_OFS)
                  ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////
  // control register
  logic             wdEnable;
  logic             wdLock;
  logic [SEL_W-1:0] wdSel;
  logic             ctrlWr;
  logic             kick;
  assign ctrlWr = doWrite && awAddr == CTRL_OFS && wStrb[0];
  assign kick   = doWrite && awAddr == CTRL_OFS && wStrb[1] && wData[CTRL_KICK_BIT];
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wdEnable <= 1'b1;
      wdLock   <= 1'b0;
      wdSel    <= SEL_MAX;
    end
    else if (ctrlWr && !wdLock)
    begin
      wdEnable <= wData[CTRL_EN_BIT];
      wdLock   <= wData[CTRL_LOCK_BIT];
      wdSel    <= wData[CTRL_SEL_LSB +: SEL_W];
    end
  end

  //////////////////////////////////////////////////////////////////
  // watchdog counter and overflow
  logic [CNT_W-1:0] count;
  logic             overflow;
  always_comb
  begin
    overflow = lfoTick && wdEnable && (count[SEL_BASE + int'(wdSel)] == 1'b1);
  end
  always_ff @(posedge mclk)
  begin
    if (reset)
      count <= '0;
    else if (kick || !wdEnable)
      count <= '0;
    else if (lfoTick)
      count <= count + 1'b1;
  end
  // reset request pulse; pin never driven
  always_ff @(posedge mclk)
  begin
    if (reset)
      sysResetReq <= 1'b0;
    else
      sysResetReq <= overflow;
  end
  assign rstPinOe = 1'b0;

  //////////////////////////////////////////////////////////////////
  // interrupt status, clear and enable
  logic [STAT_W-1:0] stat;
  logic [STAT_W-1:0] irqEn;
  logic [STAT_W-1:0] setEv;
  logic [STAT_W-1:0] clrEv;
  assign setEv = {ctrlWr & wdLock, overflow};
  assign clrEv = (doWrite && awAddr == CLEAR_OFS && wStrb[0]) ? wData[STAT_W-1:0] : '0;
  always_ff @(posedge mclk)
  begin
    if (reset)
      stat <= '0;
    else
      stat <= (stat & ~clrEv) | setEv; // set wins
  end
  always_ff @(posedge mclk)
  begin
    if (reset)
      irqEn <= '0;
    else if (doWrite && awAddr == ENABLE_OFS && wStrb[0])
      irqEn <= wData[STAT_W-1:0];
  end
  assign irq = |(stat & irqEn);

  //////////////////////////////////////////////////////////////////
  // bus read channel
  assign arready = ~rvalid;
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp  <= RESP_OKAY;
      unique case (araddr)
        CTRL_OFS:   rdata <= {24'h0, 1'b0, wdSel, 2'b0, wdLock, wdEnable};
        STAT_OFS:   rdata <= {30'h0, stat};
        ENABLE_OFS: rdata <= {30'h0, irqEn};
        default:
        begin
          rdata <= 32'h0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////
  // checks: reset request and reset pin
  a_ovf_resets: assert property (@(posedge mclk) disable iff (reset)
    overflow |=> sysResetReq)
    else $error("overflow did not request reset");
  a_req_cause: assert property (@(posedge mclk) disable iff (reset)
    sysResetReq |-> $past(overflow))
    else $error("reset request without overflow");
  a_pin_idle: assert property (@(posedge mclk) disable iff (reset)
    sysResetReq |-> !rstPinOe)
    else $error("reset pin driven");

  // checks: defaults, enable, lock and timeout select
  // lock must survive everything but a system reset
  a_reset_defaults: assert property (@(posedge mclk)
    $fell(reset) |-> wdEnable && wdSel == SEL_MAX && !wdLock)
    else $error("bad defaults after reset");
  a_disabled_quiet: assert property (@(posedge mclk) disable iff (reset)
    !wdEnable |-> !overflow)
    else $error("disabled watchdog fired");
  a_disabled_zero: assert property (@(posedge mclk) disable iff (reset)
    !wdEnable |=> count == '0)
    else $error("disabled watchdog counted");
  a_lock_holds: assert property (@(posedge mclk) disable iff (reset)
    wdLock |=> wdLock && $stable(wdEnable) && $stable(wdSel))
    else $error("locked config changed");
  a_lock_config: assert property (@(posedge mclk) disable iff (reset)
    (ctrlWr && wdLock) |=> stat[STAT_LOCK_BIT] && $stable(wdSel))
    else $error("locked write not refused");
  a_sel_write: assert property (@(posedge mclk) disable iff (reset)
    (ctrlWr && !wdLock) |=> wdSel == $past(wData[CTRL_SEL_LSB +: SEL_W]))
    else $error("timeout select not written");

  // checks: counter and oscillator tick
  // restart must still work while locked
  a_kick_clears: assert property (@(posedge mclk) disable iff (reset)
    kick |=> count == '0)
    else $error("restart did not clear");
  a_kick_locked: assert property (@(posedge mclk) disable iff (reset)
    (kick && wdLock) |=> count == '0)
    else $error("locked restart did not clear");
  a_tick_only: assert property (@(posedge mclk) disable iff (reset)
    (count != $past(count) && count != '0) |-> $past(lfoTick))
    else $error("count moved without tick");
  a_count_hold: assert property (@(posedge mclk) disable iff (reset)
    (!lfoTick && !kick && wdEnable) |=> $stable(count))
    else $error("count changed between ticks");
  a_tick_single: assert property (@(posedge mclk) disable iff (reset)
    lfoTick |=> !lfoTick)
    else $error("tick longer than one cycle");

  // checks: status flags and interrupt
  a_set_wins: assert property (@(posedge mclk) disable iff (reset)
    overflow |=> stat[STAT_OVF_BIT])
    else $error("overflow not recorded");
  a_stat_sticky: assert property (@(posedge mclk) disable iff (reset)
    (stat[STAT_OVF_BIT] && !clrEv[STAT_OVF_BIT]) |=> stat[STAT_OVF_BIT])
    else $error("status bit lost");
  a_clr_bit: assert property (@(posedge mclk) disable iff (reset)
    (clrEv[STAT_OVF_BIT] && !overflow) |=> !stat[STAT_OVF_BIT])
    else $error("status bit not cleared");
  a_irq_level: assert property (@(posedge mclk) disable iff (reset)
    (stat[STAT_OVF_BIT] && irqEn[STAT_OVF_BIT]) |-> irq)
    else $error("enabled status without interrupt");
  a_irq_mask: assert property (@(posedge mclk) disable iff (reset)
    (irqEn == '0) |-> !irq)
    else $error("masked interrupt raised");

  // checks: bus answers stand until taken
  a_write_answer: assert property (@(posedge mclk) disable iff (reset)
    doWrite |=> bvalid)
    else $error("write not answered");
  a_read_answer: assert property (@(posedge mclk) disable iff (reset)
    (arvalid && arready) |=> rvalid)
    else $error("read not answered");
  a_b_stands: assert property (@(posedge mclk) disable iff (reset)
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_stands: assert property (@(posedge mclk) disable iff (reset)
    (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped");
  a_b_release: assert property (@(posedge mclk) disable iff (reset)
    (bvalid && bready) |=> !bvalid)
    else $error("write response repeated");
  a_aw_blocked: assert property (@(posedge mclk) disable iff (reset)
    bvalid |-> !awready && !wready)
    else $error("write taken while answering");
  a_ar_blocked: assert property (@(posedge mclk) disable iff (reset)
    rvalid |-> !arready)
    else $error("read taken while answering");
  a_bresp_code: assert property (@(posedge mclk) disable iff (reset)
    (doWrite && awAddr == STAT_OFS) |=> bresp == RESP_SLVERR)
    else $error("status write not refused");
  a_rresp_code: assert property (@(posedge mclk) disable iff (reset)
    (arvalid && arready && araddr == CLEAR_OFS) |=> rresp == RESP_SLVERR)
    else $error("clear read not refused");
endmodule : wdt_timer

// ### pkg/wdt_pkg.sv
package wdt_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS    = 4'h0;
  localparam logic [3:0] STAT_OFS    = 4'h4;
  localparam logic [3:0] CLEAR_OFS   = 4'h8;
  localparam logic [3:0] ENABLE_OFS  = 4'hc;
  // control fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_LOCK_BIT = 1;
  localparam int CTRL_SEL_LSB  = 4;
  localparam int SEL_W         = 3;
  localparam int CTRL_KICK_BIT = 8;
  localparam logic [SEL_W-1:0] SEL_MAX = 3'h7;
  // status fields
  localparam int STAT_OVF_BIT  = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_W        = 2;
  // timeout base: overflow on the oscillator tick after 2**(SEL_BASE+sel) ticks
  localparam int SEL_BASE      = 6;
  localparam int CNT_W         = SEL_BASE + 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : wdt_pkg
